//--- design/drab_decode.sv
/*
 * drab_decode: turns the nine readback select bits into a source choice.
 * assumes: purely combinational, used by drab_top.
 */
`timescale 1ns/10ps
`default_nettype none
module drab_decode (
   input wire logic [8:0] sel_i,     // F15..F7 of the stored selection
   output logic is_chan_o,           // per-channel register chosen
   output logic [1:0] kind_o,        // which per-channel register
   output logic [3:0] chan_o,        // channel 0..15
   output logic [2:0] special_o,     // special register index
   output logic valid_o              // not a reserved code
);
   logic [5:0] code_ch;
   logic [5:0] ch_off;
   // ==========================================================
   // decode
   always_comb begin
      code_ch = sel_i[5:0];
      ch_off = code_ch - drab_pkg::CH_BASE;
      is_chan_o = 1'b0;
      kind_o = sel_i[7:6];
      chan_o = ch_off[3:0];
      special_o = 3'h0;
      valid_o = 1'b0;
      if (!sel_i[8]) begin  // see R1
         is_chan_o = 1'b1;
         valid_o = (code_ch >= drab_pkg::CH_BASE) && (code_ch <= drab_pkg::CH_LAST);
      end else begin  // see R2
         unique case (sel_i[7:0])
            drab_pkg::SP_CONTROL: begin special_o = 3'h0; valid_o = 1'b1; end
            drab_pkg::SP_OFFSET_ZERO: begin special_o = 3'h1; valid_o = 1'b1; end
            drab_pkg::SP_OFFSET_ONE: begin special_o = 3'h2; valid_o = 1'b1; end
            drab_pkg::SP_BANK_LOW: begin special_o = 3'h3; valid_o = 1'b1; end
            drab_pkg::SP_BANK_HIGH: begin special_o = 3'h4; valid_o = 1'b1; end
            drab_pkg::SP_GPIO: begin special_o = 3'h5; valid_o = 1'b1; end
            default: begin special_o = 3'h0; valid_o = 1'b0; end  // reserved, see R12
         endcase
      end
   end
endmodule : drab_decode
`default_nettype wire

//--- design/drab_pkg.sv
/*
 * drab_pkg: constants for the readback select and a/b bank select block.
 * assumes: 24-bit frames, mode bits [23:22], special function code in [21:16].
 */
package drab_pkg;
   // ==========================================================
   // frame layout
   localparam int unsigned FRAME_W = 24;
   localparam logic [1:0] MODE_SPECIAL = 2'h0;   // special function mode
   localparam logic [5:0] SF_NOP = 6'h00;        // no-operation
   localparam logic [5:0] SF_CONTROL_WR = 6'h01; // control register write
   localparam logic [5:0] SF_OFFSET_ZERO_WR = 6'h02; // offset dac zero data write
   localparam logic [5:0] SF_OFFSET_ONE_WR = 6'h03;  // offset dac one data write
   localparam logic [5:0] SF_RB_SELECT = 6'h05;  // select register for readback
   localparam logic [5:0] SF_BANK_LOW_WR = 6'h06;
   localparam logic [5:0] SF_BANK_HIGH_WR = 6'h07;
   localparam logic [5:0] SF_BANK_BLOCK_WR = 6'h0b;
   localparam logic [5:0] SF_GPIO_WR = 6'h0d;
   // ==========================================================
   // readback select field: data bits 15..7 (F15..F7)
   localparam int unsigned SEL_HI = 15;
   localparam int unsigned SEL_LO = 7;
   localparam logic [1:0] KIND_IN_A = 2'h0;      // F14:F13 for per-channel reads
   localparam logic [1:0] KIND_IN_B = 2'h1;
   localparam logic [1:0] KIND_OFFSET = 2'h2;
   localparam logic [1:0] KIND_GAIN = 2'h3;
   localparam logic [5:0] CH_BASE = 6'h08;       // channel 0 code
   localparam logic [5:0] CH_LAST = 6'h17;       // channel 15 code
   localparam logic [7:0] SP_CONTROL = 8'h01;    // low 8 select bits, top bit set
   localparam logic [7:0] SP_OFFSET_ZERO = 8'h02;
   localparam logic [7:0] SP_OFFSET_ONE = 8'h03;
   localparam logic [7:0] SP_BANK_LOW = 8'h06;
   localparam logic [7:0] SP_BANK_HIGH = 8'h07;
   localparam logic [7:0] SP_GPIO = 8'h0b;
   // ==========================================================
   // reset values
   localparam logic [7:0] BANK_RST = 8'h00;
   localparam logic [13:0] OFS_RST = 14'h0000;
   localparam logic [15:0] DATA_RST = 16'h0000;
endpackage : drab_pkg

//--- design/drab_top.sv
/*
 * drab_top: readback selection and a/b bank selection of a 16-channel dac.
 * assumes: a frame deserialiser outside hands each 24-bit word as a one-cycle
 * strobe; per-channel register contents come in on flat buses; the readback
 * word is picked up by the serialiser for the following frame.
 */
`timescale 1ns/10ps
`default_nettype none
// How it works
// R1: top bits pick A/B/offset/gain, six bits channel
// R2: top bit set picks a special register
// R3: gpio read returns pin state in bit 0; code returns gpio_out_q instead while gpio_oe_q is set
// R4: low seven data bits ignored for selection
// R5: host zeroes low seven bits on gpio read
// R6: select reg 0 covers ch0-7, reg 1 ch8-15
// R7: select bit 0 uses bank A, 1 bank B
// R8: select frame, then nop frame shifts data
// R9: special readback command stores the selection code
// R10: gpio input level readable in bit 0
// R11: block write loads both select registers together
// R12: reserved code returns zeros, changes nothing
module drab_top (
   input wire logic REF_CLK_I,
   input wire logic RST_N_I,
   input wire logic FRAME_VALID_I,             // one-cycle strobe, full frame received
   input wire logic [23:0] FRAME_I,            // received frame
   input wire logic [255:0] INPUT_A_I,         // input_word_bank_a, 16 x 16
   input wire logic [255:0] INPUT_B_I,         // input_word_bank_b
   input wire logic [255:0] OFFSET_TRIM_I,
   input wire logic [255:0] GAIN_TRIM_I,
   input wire logic [255:0] OUTPUT_A_I,        // output_word_bank_a
   input wire logic [255:0] OUTPUT_B_I,        // output_word_bank_b
   input wire logic [15:0] CONTROL_I,          // control register contents
   input wire logic GPIO_PIN_I,                // sampled gpio pin level
   output logic [15:0] READBACK_O,             // word shifted out in the nop frame
   output logic READBACK_VALID_O,              // readback word is armed for this frame
   output logic [7:0] BANK_SELECT_LOW_O,
   output logic [7:0] BANK_SELECT_HIGH_O,
   output logic [13:0] OFFSET_DAC_ZERO_O,      // offset_dac_zero_data
   output logic [13:0] OFFSET_DAC_ONE_O,       // offset_dac_one_data
   output logic GPIO_OUT_O,
   output logic GPIO_OE_O,
   output logic [255:0] DAC_WORD_O             // chosen output word per channel
);
   // ==========================================================
   // frame fields
   logic [1:0] mode;
   logic [5:0] sf_code;
   logic [15:0] data;
   logic is_special;
   assign mode = FRAME_I[23:22];
   assign sf_code = FRAME_I[21:16];
   assign data = FRAME_I[15:0];
   assign is_special = FRAME_VALID_I && (mode == drab_pkg::MODE_SPECIAL);

   // stored state
   logic [7:0] bank_select_low_channels_q;
   logic [7:0] bank_select_high_channels_q;
   logic [13:0] offset_dac_zero_data_q;
   logic [13:0] offset_dac_one_data_q;
   logic [8:0] sel_q;            // stored readback selection
   logic sel_armed_q;            // a selection waits for the nop frame
   logic gpio_out_q;
   logic gpio_oe_q;
   logic [15:0] rb_q;
   logic rb_valid_q;

   // ==========================================================
   // a/b bank select registers; block write loads both at once
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         bank_select_low_channels_q <= drab_pkg::BANK_RST;
         bank_select_high_channels_q <= drab_pkg::BANK_RST;
      end else if (is_special) begin
         if (sf_code == drab_pkg::SF_BANK_LOW_WR) begin
            bank_select_low_channels_q <= data[7:0];
         end else if (sf_code == drab_pkg::SF_BANK_HIGH_WR) begin
            bank_select_high_channels_q <= data[7:0];
         end else if (sf_code == drab_pkg::SF_BANK_BLOCK_WR) begin  // see R11
            bank_select_low_channels_q <= data[7:0];
            bank_select_high_channels_q <= data[7:0];
         end
      end
   end

   // offset dac data and gpio configuration
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         offset_dac_zero_data_q <= drab_pkg::OFS_RST;
         offset_dac_one_data_q <= drab_pkg::OFS_RST;
         gpio_out_q <= 1'b0;
         gpio_oe_q <= 1'b0;
      end else if (is_special) begin
         if (sf_code == drab_pkg::SF_OFFSET_ZERO_WR) begin
            offset_dac_zero_data_q <= data[13:0];
         end
         if (sf_code == drab_pkg::SF_OFFSET_ONE_WR) begin
            offset_dac_one_data_q <= data[13:0];
         end
         if (sf_code == drab_pkg::SF_GPIO_WR) begin
            gpio_oe_q <= data[1];   // 1: output, 0: input
            gpio_out_q <= data[0];
         end
      end
   end

   // ==========================================================
   // readback selection: only F15..F7 kept, F6..F0 dropped
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sel_q <= 9'h000;
         sel_armed_q <= 1'b0;
      end else if (FRAME_VALID_I) begin
         if (is_special && sf_code == drab_pkg::SF_RB_SELECT) begin  // see R9
            sel_q <= data[drab_pkg::SEL_HI:drab_pkg::SEL_LO];  // see R4
            sel_armed_q <= 1'b1;
         end else begin
            sel_armed_q <= 1'b0;  // any other frame uses up the selection
         end
      end
   end

   // decode of the stored selection
   logic d_is_chan;
   logic [1:0] d_kind;
   logic [3:0] d_chan;
   logic [2:0] d_special;
   logic d_valid;
   drab_decode u_decode (
      .sel_i(sel_q),
      .is_chan_o(d_is_chan),
      .kind_o(d_kind),
      .chan_o(d_chan),
      .special_o(d_special),
      .valid_o(d_valid)
   );

   // ==========================================================
   // readback word mux
   logic [15:0] rb_d;
   logic [7:0] ch_pos;
   always_comb begin
      ch_pos = {d_chan, 4'h0};
      rb_d = drab_pkg::DATA_RST;
      if (!d_valid) begin
         rb_d = drab_pkg::DATA_RST;  // see R12
      end else if (d_is_chan) begin  // see R1
         unique case (d_kind)
            drab_pkg::KIND_IN_A: rb_d = INPUT_A_I[ch_pos +: 16];
            drab_pkg::KIND_IN_B: rb_d = INPUT_B_I[ch_pos +: 16];
            drab_pkg::KIND_OFFSET: rb_d = OFFSET_TRIM_I[ch_pos +: 16];
            drab_pkg::KIND_GAIN: rb_d = GAIN_TRIM_I[ch_pos +: 16];
         endcase
      end else begin  // see R2
         unique case (d_special)
            3'h0: rb_d = CONTROL_I;
            3'h1: rb_d = {2'h0, offset_dac_zero_data_q};
            3'h2: rb_d = {2'h0, offset_dac_one_data_q};
            3'h3: rb_d = {8'h00, bank_select_low_channels_q};
            3'h4: rb_d = {8'h00, bank_select_high_channels_q};
            3'h5: rb_d = {15'h0000, gpio_oe_q ? gpio_out_q : GPIO_PIN_I};  // see R3, R10
            default: rb_d = drab_pkg::DATA_RST;
         endcase
      end
   end

   // the nop frame after a selection carries the word out
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rb_q <= drab_pkg::DATA_RST;
         rb_valid_q <= 1'b0;
      end else if (FRAME_VALID_I) begin
         // captured at the nop frame's end marks what it shifted out  (see R8)
         rb_valid_q <= sel_armed_q && is_special && sf_code == drab_pkg::SF_NOP;
         if (sel_armed_q) begin
            rb_q <= rb_d;
         end
      end else if (!sel_armed_q) begin
         rb_valid_q <= rb_valid_q;
      end
   end

   // ==========================================================
   // per-channel bank choice: reg 0 -> ch 7..0, reg 1 -> ch 15..8
   logic [15:0] bank_b;
   logic [255:0] dac_word_q;
   assign bank_b = {bank_select_high_channels_q, bank_select_low_channels_q};  // see R6
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         dac_word_q <= '0;
      end else begin
         for (int i = 0; i < 16; i++) begin
            dac_word_q[i*16 +: 16] <= bank_b[i] ? OUTPUT_B_I[i*16 +: 16]
                                                : OUTPUT_A_I[i*16 +: 16];  // see R7
         end
      end
   end

   assign READBACK_O = rb_q;
   assign READBACK_VALID_O = rb_valid_q;
   assign BANK_SELECT_LOW_O = bank_select_low_channels_q;
   assign BANK_SELECT_HIGH_O = bank_select_high_channels_q;
   assign OFFSET_DAC_ZERO_O = offset_dac_zero_data_q;
   assign OFFSET_DAC_ONE_O = offset_dac_one_data_q;
   assign GPIO_OUT_O = gpio_out_q;
   assign GPIO_OE_O = gpio_oe_q;
   assign DAC_WORD_O = dac_word_q;

   // ==========================================================
   // checks
   AST_BLOCK_WRITE: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)  // see R11
      is_special && sf_code == drab_pkg::SF_BANK_BLOCK_WR |=>
      bank_select_low_channels_q == $past(data[7:0]) &&
      bank_select_high_channels_q == $past(data[7:0]))
      else $error("block write did not load both select registers");
   AST_SEL_STORE: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)  // see R4
      is_special && sf_code == drab_pkg::SF_RB_SELECT |=>
      sel_armed_q && sel_q == $past(data[15:7]))
      else $error("readback selection not stored");
   AST_RESERVED_ZERO: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)  // see R12
      FRAME_VALID_I && sel_armed_q && !d_valid |=> rb_q == 16'h0000)
      else $error("reserved code returned nonzero data");
   AST_NOP_SHIFT: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)  // see R8
      FRAME_VALID_I && sel_armed_q && is_special && sf_code == drab_pkg::SF_NOP
      |=> rb_valid_q && rb_q == $past(rb_d))
      else $error("nop frame did not deliver selected word");
   AST_GPIO_BIT: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)  // see R3
      FRAME_VALID_I && sel_armed_q && sel_q == {1'b1, drab_pkg::SP_GPIO} && !gpio_oe_q
      |=> rb_q == {15'h0000, $past(GPIO_PIN_I)})
      else $error("gpio readback wrong");
   AST_BANK_CH0: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)  // see R7
      1'b1 |=> dac_word_q[15:0] == ($past(bank_select_low_channels_q[0]) ?
      $past(OUTPUT_B_I[15:0]) : $past(OUTPUT_A_I[15:0])))
      else $error("channel 0 bank choice wrong");
   AST_BANK_CH15: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)  // see R6
      1'b1 |=> dac_word_q[255:240] == ($past(bank_select_high_channels_q[7]) ?
      $past(OUTPUT_B_I[255:240]) : $past(OUTPUT_A_I[255:240])))
      else $error("channel 15 bank choice wrong");
   AST_CHAN_READ: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)  // see R1
      FRAME_VALID_I && sel_armed_q && sel_q == 9'h008 |=> rb_q == $past(INPUT_A_I[15:0]))
      else $error("channel 0 input A readback wrong");
endmodule : drab_top
`default_nettype wire

//--- dv/drab_host_model.sv
/* drab_host_model: host side that feeds whole frames to drab_top.
   assumes: one clock, frames strobed for one cycle, driven 1 ns after the edge. */
`timescale 1ns/10ps
`default_nettype none
module drab_host_model (
   input wire logic clk_i,
   output logic frame_valid_o,
   output logic [23:0] frame_o
);
   // ===========================================================
   // idle state at time zero
   initial begin
      frame_valid_o = 1'b0;
      frame_o = 24'h000000;
   end
   // ===========================================================
   // one special-mode frame
   // the bus shows the inverse afterwards so a stale word is never reused
   task automatic send(input logic [5:0] code, input logic [15:0] data);
      @(posedge clk_i);
      #1;
      frame_valid_o = 1'b1;
      frame_o = {drab_pkg::MODE_SPECIAL, code, data};
      @(posedge clk_i);
      #1;
      frame_valid_o = 1'b0;
      frame_o = ~frame_o;
   endtask : send
   // select frame then nop frame; low bits zeroed for the gpio read
   task automatic read(input logic [8:0] sel, input logic [6:0] low);
      logic [6:0] l;
      l = (sel == {1'b1, drab_pkg::SP_GPIO}) ? 7'h00 : low;
      send(drab_pkg::SF_RB_SELECT, {sel, l});
      send(drab_pkg::SF_NOP, 16'h0000);
   endtask : read
endmodule : drab_host_model
`default_nettype wire

//--- dv/tb_top.sv
/* tb_top: self-checking bench for drab_top.
   assumes: drab_host_model issues frames; readback expectations go in a queue. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic frame_valid;
   logic [23:0] frame;
   logic [255:0] in_a, in_b, ofs_t, gain_t, out_a, out_b, dac_word;
   logic [15:0] ctrl, rb;
   logic gpio_pin, rb_valid, prev_valid, gpio_out, gpio_oe;
   logic [7:0] bs_lo, bs_hi, b0, b1;
   logic [13:0] off_zero, off_one, o0, o1;
   logic [15:0] exp_q[$]; // expected readback words, oldest first
   int err_count = 0;
   int n_checks = 0;
   int seed = 3416;
   // ===========================================================
   // clock and instances
   always #50 ref_clk = ~ref_clk;
   drab_host_model i_drab_host_model (.clk_i(ref_clk), .frame_valid_o(frame_valid),
      .frame_o(frame));
   drab_top i_drab_top (.REF_CLK_I(ref_clk), .RST_N_I(rst_n), .FRAME_VALID_I(frame_valid),
      .FRAME_I(frame), .INPUT_A_I(in_a), .INPUT_B_I(in_b), .OFFSET_TRIM_I(ofs_t),
      .GAIN_TRIM_I(gain_t), .OUTPUT_A_I(out_a), .OUTPUT_B_I(out_b), .CONTROL_I(ctrl),
      .GPIO_PIN_I(gpio_pin), .READBACK_O(rb), .READBACK_VALID_O(rb_valid),
      .BANK_SELECT_LOW_O(bs_lo), .BANK_SELECT_HIGH_O(bs_hi), .OFFSET_DAC_ZERO_O(off_zero),
      .OFFSET_DAC_ONE_O(off_one), .GPIO_OUT_O(gpio_out), .GPIO_OE_O(gpio_oe),
      .DAC_WORD_O(dac_word));
   // ===========================================================
   // comparison and closing
   task automatic check(input logic [255:0] seen, input logic [255:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask : check
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up
   // queue a word, then run the two-frame read with random don't-care bits
   task automatic rd(input logic [8:0] sel, input logic [15:0] e);
      exp_q.push_back(e);
      i_drab_host_model.read(sel, 7'($random(seed)));
   endtask : rd
   // every channel word follows its select bit
   task automatic chk_dac(input logic [15:0] s);
      for (int c = 0; c < 16; c++) begin
         check(dac_word[16*c+:16], s[c] ? out_b[16*c+:16] : out_a[16*c+:16]);
      end
   endtask : chk_dac
   // ===========================================================
   // monitor: a fresh readback strobe takes the oldest note
   always @(negedge ref_clk) begin
      if (rb_valid === 1'b1 && prev_valid !== 1'b1) begin
         check(rb, (exp_q.size() != 0) ? exp_q.pop_front() : 16'hxxxx);
      end
      prev_valid = rb_valid;
   end
   // watchdog, far beyond the roughly 155 cycles the tests need
   initial begin
      #5000000;
      err_count++;
      wrap_up();
   end
   // ===========================================================
   // main sequence
   initial begin
      logic [15:0] e;
      logic [3:0] ch;
      logic [39:0] rsv; // reserved special codes, one byte each
      ctrl = 16'($random(seed));
      gpio_pin = 1'b0;
      for (int j = 0; j < 8; j++) begin
         in_a[32*j+:32] = $random(seed);
         in_b[32*j+:32] = $random(seed);
         ofs_t[32*j+:32] = $random(seed);
         gain_t[32*j+:32] = $random(seed);
         out_a[32*j+:32] = $random(seed);
         out_b[32*j+:32] = $random(seed);
      end
      repeat (8) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      check({bs_hi, bs_lo}, {drab_pkg::BANK_RST, drab_pkg::BANK_RST});
      // per-channel reads, channel 0, 15 and random ones, all four kinds
      for (int k = 0; k < 4; k++) begin
         for (int i = 0; i < 4; i++) begin
            ch = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($random(seed));
            e = (k == 0) ? in_a[16*ch+:16] : (k == 1) ? in_b[16*ch+:16] :
               (k == 2) ? ofs_t[16*ch+:16] : gain_t[16*ch+:16];
            rd({1'b0, 2'(k), 6'(drab_pkg::CH_BASE + {2'b00, ch})}, e);
         end
      end
      $display("test channel reads done");
      // register writes, then special reads
      o0 = 14'($random(seed));
      o1 = 14'($random(seed));
      b0 = 8'($random(seed));
      b1 = 8'($random(seed));
      i_drab_host_model.send(drab_pkg::SF_OFFSET_ZERO_WR, {2'b11, o0});
      i_drab_host_model.send(drab_pkg::SF_OFFSET_ONE_WR, {2'b11, o1});
      i_drab_host_model.send(drab_pkg::SF_BANK_LOW_WR, {8'hff, b0});
      i_drab_host_model.send(drab_pkg::SF_BANK_HIGH_WR, {8'hff, b1});
      i_drab_host_model.send(drab_pkg::SF_GPIO_WR, 16'h0003);
      repeat (2) @(posedge ref_clk);
      #1;
      check({off_one, off_zero, bs_hi, bs_lo, gpio_oe, gpio_out}, {o1, o0, b1, b0, 2'b11});
      chk_dac({b1, b0});
      rd({1'b1, drab_pkg::SP_CONTROL}, ctrl);
      rd({1'b1, drab_pkg::SP_OFFSET_ZERO}, {2'b00, o0});
      rd({1'b1, drab_pkg::SP_OFFSET_ONE}, {2'b00, o1});
      rd({1'b1, drab_pkg::SP_BANK_LOW}, {8'h00, b0});
      rd({1'b1, drab_pkg::SP_BANK_HIGH}, {8'h00, b1});
      rd({1'b1, drab_pkg::SP_GPIO}, 16'h0001);
      i_drab_host_model.send(drab_pkg::SF_GPIO_WR, 16'h0000);
      gpio_pin = 1'b1;
      rd({1'b1, drab_pkg::SP_GPIO}, 16'h0001);
      @(posedge ref_clk);
      #1;
      gpio_pin = 1'b0;
      rd({1'b1, drab_pkg::SP_GPIO}, 16'h0000);
      $display("test special reads done");
      // reserved codes return zero and disturb nothing
      rsv = {8'hff, 8'h0a, 8'h09, 8'h08, 8'h04};
      for (int i = 0; i < 5; i++) begin
         rd({1'b1, rsv[8*i+:8]}, 16'h0000);
      end
      rd({3'b000, 6'h07}, 16'h0000);
      rd({3'b011, 6'h18}, 16'h0000);
      check({off_one, off_zero, bs_hi, bs_lo}, {o1, o0, b1, b0});
      $display("test reserved codes done");
      // block write to all ones then all zeros
      i_drab_host_model.send(drab_pkg::SF_BANK_BLOCK_WR, 16'h00ff);
      repeat (2) @(posedge ref_clk);
      #1;
      check({bs_hi, bs_lo}, 16'hffff);
      chk_dac(16'hffff);
      i_drab_host_model.send(drab_pkg::SF_BANK_BLOCK_WR, 16'h0000);
      repeat (2) @(posedge ref_clk);
      #1;
      check({bs_hi, bs_lo}, 16'h0000);
      chk_dac(16'h0000);
      check(32'(exp_q.size()), 32'h0);
      $display("test block write done");
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
